// file: bench/rsc_reset_source_control_properties.sv
// Concurrent checks on the reset source control ports
`timescale 1ns/100ps
`default_nettype none
module rsc_props #(
  parameter int unsigned LOSS_TIMEOUT_CYCLES = 20,
  parameter int unsigned HOLD_CYCLES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Sources and system reset
  input wire logic wdt_overflow,
  input wire logic flash_error,
  input wire logic low_power,
  input wire logic ext_rst_n_raw,
  input wire logic sys_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Bus cycles aimed at this register only
  wire logic sel = sfr_page == 4'h0 && sfr_addr == 8'hef;
  wire logic sel_rd = sel && sfr_rd;
  sequence sw_force;
    sel && sfr_wr && sfr_wdata[4] && !sys_reset;
  endsequence
  sequence plain_read;
    sel_rd && !sfr_rmw;
  endsequence
  sequence rmw_read;
    sel_rd && sfr_rmw;
  endsequence
  sw_force_a: assert property (sw_force |=> sys_reset)
    else $error("software force gave no reset");
  flash_reset_a: assert property (flash_error && !sys_reset |=> sys_reset)
    else $error("flash fault gave no reset");
  wdt_reset_a: assert property (
    wdt_overflow && !low_power && !sys_reset |=> sys_reset)
    else $error("watchdog gave no reset");
  pin_reset_a: assert property (
    $fell(ext_rst_n_raw) && !sys_reset |-> ##[1:4] sys_reset)
    else $error("pin low gave no reset");
  // Hold shorter than four cycles would be a glitch to the chip
  hold_min_a: assert property ($rose(sys_reset) |-> sys_reset [*4])
    else $error("system reset too short");
  rdata_hold_a: assert property (!sel_rd [*2] |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  rmw_mask_a: assert property (
    rmw_read |-> ##1 (sfr_rdata & 8'h59) == 8'h00)
    else $error("modify read shows flag bits");
  cause_one_a: assert property (plain_read |-> ##1 $onehot0(sfr_rdata))
    else $error("more than one cause flag");
endmodule : rsc_props

bind rsc_reset_source_control rsc_props #(
  .LOSS_TIMEOUT_CYCLES(LOSS_TIMEOUT_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)
) i_props (
  .sys_clk, .rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_rmw,
  .sfr_wdata, .sfr_rdata, .wdt_overflow, .flash_error, .low_power,
  .ext_rst_n_raw, .sys_reset
);
`default_nettype wire

// file: bench/tb_rsc_reset_source_control.sv
// Self-checking bench for the reset cause and enable register
`timescale 1ns/100ps
`default_nettype none
module tb_rsc_reset_source_control;
  // Stimulus and observed signals
  logic sys_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic sfr_rmw = 1'b0, rtc_clk_detect_en = 1'b0, rtc_clk_slow = 1'b0;
  logic rtc_alarm_en = 1'b0, rtc_alarm_match = 1'b0, cmp0_out_raw = 1'b1;
  logic cmp0_wake_en = 1'b0, wdt_overflow = 1'b0, flash_error = 1'b0;
  logic vdd_below_rst = 1'b0, low_power = 1'b0, sysclk_mon = 1'b0;
  logic ext_rst_n_raw = 1'b1, mon_run = 1'b1, sys_reset;
  logic [3:0] sfr_page = 4'h0;
  logic [7:0] sfr_addr = 8'hef, sfr_wdata = 8'h00, sfr_rdata, d;
  int fail_count = 0, total_checks = 0;

  // Short counts keep the clock-loss and hold phases brief
  rsc_reset_source_control #(
    .LOSS_TIMEOUT_CYCLES(20), .HOLD_CYCLES(4)
  ) i_dut (
    .sys_clk, .rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_rmw,
    .sfr_wdata, .sfr_rdata, .rtc_clk_detect_en, .rtc_clk_slow,
    .rtc_alarm_en, .rtc_alarm_match, .cmp0_out_raw, .cmp0_wake_en,
    .wdt_overflow, .flash_error, .vdd_below_rst, .low_power,
    .sysclk_mon, .ext_rst_n_raw, .sys_reset
  );

  always #5 sys_clk = ~sys_clk;
  // Watched clock copy; stopping it models a stalled clock
  always @(posedge sys_clk) #1 if (mon_run) sysclk_mon = ~sysclk_mon;

  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // Bus cycles: one-cycle strobe, then one idle edge
  task automatic wr(input logic [7:0] v);
    sfr_wr = 1'b1;
    sfr_wdata = v;
    @(posedge sys_clk);
    #1;
    sfr_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : wr

  task automatic rd(input logic rmw, output logic [7:0] v);
    sfr_rd = 1'b1;
    sfr_rmw = rmw;
    @(posedge sys_clk);
    #1;
    sfr_rd = 1'b0;
    sfr_rmw = 1'b0;
    @(posedge sys_clk);
    #1;
    v = sfr_rdata;
  endtask : rd

  // Bounded wait for the system reset level
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (sys_reset !== v && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (sys_reset !== v) begin
      chk("reset wait", {7'h00, sys_reset}, {7'h00, v});
      end_sim();
    end
  endtask : wait_rst

  // Raise or drop one reset source by index; other indexes drive flash and watchdog together
  task automatic src(input int k, input logic v);
    case (k)
      0: flash_error = v;
      1: wdt_overflow = v;
      2: {rtc_alarm_en, rtc_alarm_match} = {v, v};
      3: {rtc_clk_detect_en, rtc_clk_slow} = {v, v};
      4: cmp0_out_raw = !v;
      5: ext_rst_n_raw = !v;
      6: vdd_below_rst = v;
      7: mon_run = !v;
      default: {flash_error, wdt_overflow} = {v, v};
    endcase
  endtask : src

  // Enable, fire, drop at reset entry, then read the cause
  task automatic run_src(input int k, input logic [7:0] en, exp);
    logic [7:0] v;
    wr(en);
    src(k, 1'b1);
    wait_rst(1'b1);
    src(k, 1'b0);
    wait_rst(1'b0);
    rd(1'b0, v);
    chk("cause", v, exp);
  endtask : run_src

  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rd(1'b0, d);
    chk("por cause", d, 8'h02);
    rd(1'b1, d);
    chk("por enables", d, 8'h02);
    wr(8'he7);
    rd(1'b1, d);
    chk("enables", d, 8'ha6);
    rd(1'b0, d);
    chk("flags kept", d, 8'h02);
    sfr_page = 4'h1;
    rd(1'b1, d);
    sfr_page = 4'h0;
    chk("unmapped", d, 8'h02);
    wr(8'h00);
    rd(1'b1, d);
    chk("cleared", d, 8'h00);
    src(4, 1'b1);
    repeat (10) @(posedge sys_clk);
    #1;
    chk("masked cmp", {7'h00, sys_reset}, 8'h00);
    src(4, 1'b0);
    wr(8'h10);
    // Enable write during the hold must be dropped
    wr(8'ha6);
    wait_rst(1'b1);
    wait_rst(1'b0);
    rd(1'b0, d);
    chk("sw cause", d, 8'h10);
    rd(1'b1, d);
    chk("write in hold", d, 8'h02);
    run_src(0, 8'h00, 8'h40);
    run_src(1, 8'h00, 8'h08);
    run_src(2, 8'h80, 8'h80);
    run_src(3, 8'h80, 8'h80);
    run_src(4, 8'h20, 8'h20);
    run_src(5, 8'h00, 8'h01);
    run_src(6, 8'h02, 8'h02);
    run_src(7, 8'h04, 8'h04);
    run_src(8, 8'h00, 8'h08);
    low_power = 1'b1;
    run_src(2, 8'h80, 8'h80);
    // Watchdog is ignored in low power
    src(1, 1'b1);
    repeat (10) @(posedge sys_clk);
    #1;
    chk("sleep wdt", {7'h00, sys_reset}, 8'h00);
    src(1, 1'b0);
    // Comparator keeps its reset in low power as a wake source
    cmp0_wake_en = 1'b1;
    run_src(4, 8'h20, 8'h20);
    cmp0_wake_en = 1'b0;
    low_power = 1'b0;
    end_sim();
  end
endmodule : tb_rsc_reset_source_control
`default_nettype wire

// file: rtl/rsc_clock_loss_detector.sv
// Watches a copy of the system clock and flags a stall
`timescale 1ns/100ps
`default_nettype none
module rsc_clock_loss_detector #(
  parameter int unsigned TIMEOUT_CYCLES = rsc_pkg::RSC_LOSS_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Monitored clock copy, asynchronous to sys_clk
  input wire logic mon_clk_raw,
  // Detector armed
  input wire logic enable,
  // Monitored clock stuck high or low too long
  output logic missing
);

  localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic last_q, last_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic missing_q, missing_d;

  // Count cycles since the last level change; a stuck level either way
  // runs the counter out
  always_comb begin
    sync1_d = mon_clk_raw;
    sync2_d = sync1_q;
    last_d = sync2_q;
    cnt_d = cnt_q;
    missing_d = 1'b0;
    if (!enable || (sync2_q != last_q)) begin
      cnt_d = '0;
    end else if (cnt_q != LIMIT) begin
      cnt_d = cnt_q + ONE;
    end
    if (enable && (cnt_q == LIMIT)) begin
      missing_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
      cnt_q <= '0;
      missing_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      last_q <= last_d;
      cnt_q <= cnt_d;
      missing_q <= missing_d;
    end
  end

  assign missing = missing_q;

endmodule : rsc_clock_loss_detector
`default_nettype wire

// file: rtl/rsc_reset_source_control.sv
// Reset source selection, cause recording and system reset sequencing
// What this block does
// - Real-time clock requests reset on oscillator failure or alarm match.
// - Oscillator-failure event needs detector enabled and clock below about 20 kHz.
// - Alarm event needs alarm enabled and counter equal to alarm registers.
// - Bit 7 write enables or disables real-time clock as reset source.
// - Enabled real-time clock reset still works in Suspend or Sleep.
// - Internal resets never drive the external reset pin.
// - Writing one to bit 4 forces a full system reset at once.
// - After software reset, bit 4 reads one.
// - Register is 8 bits at address 0xEF, page 0x0.
// - Bit 7 reads one when real-time clock caused last reset.
// - Bit 6 read-only, one after flash error reset; writes ignored.
// - Bit 5 enables comparator reset; reads one if comparator caused it.
// - Bit 3 read-only, one after watchdog overflow reset.
// - Bit 2 enables clock-loss detector; reads one after its timeout reset.
// - Bit 1 reads one after power-on or supply reset; writes enable monitor.
// - When bit 1 reads one, other bits are indeterminate.
// - Read-modify-write on the register is safe for the enables.
// - Bit 0 read-only, one after external pin reset.
// - Clock stuck high or low over 100 us causes a reset.
// - Pin flag is set on entering an external pin reset.
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_source_control #(
  parameter int unsigned LOSS_TIMEOUT_CYCLES =
    rsc_pkg::RSC_LOSS_TIMEOUT_CYCLES,
  parameter int unsigned HOLD_CYCLES = rsc_pkg::RSC_RESET_HOLD_CYCLES
) (
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic rst,
  // Special function register bus
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Real-time clock conditions
  input wire logic rtc_clk_detect_en,
  input wire logic rtc_clk_slow,
  input wire logic rtc_alarm_en,
  input wire logic rtc_alarm_match,
  // Comparator0, output low requests reset
  input wire logic cmp0_out_raw,
  input wire logic cmp0_wake_en,
  // Other on-chip sources
  input wire logic wdt_overflow,
  input wire logic flash_error,
  input wire logic vdd_below_rst,
  input wire logic low_power,
  input wire logic sysclk_mon,
  // External active-low reset pin, asynchronous
  input wire logic ext_rst_n_raw,
  // System reset to the rest of the chip
  output logic sys_reset
);

  localparam logic [rsc_pkg::RSC_HOLD_W-1:0] HOLD_LOAD =
    rsc_pkg::RSC_HOLD_W'(HOLD_CYCLES - 1);
  localparam logic [rsc_pkg::RSC_HOLD_W-1:0] HOLD_ONE =
    rsc_pkg::RSC_HOLD_W'(1);

  // Synchronisers for the pin and the comparator output
  logic pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;
  logic cmp_s1_q, cmp_s1_d, cmp_s2_q, cmp_s2_d;

  // Sequencer, enables and cause flags
  rsc_pkg::rsc_state_e state_q, state_d;
  logic [rsc_pkg::RSC_HOLD_W-1:0] hold_q, hold_d;
  logic [7:0] enable_q, enable_d;
  logic [7:0] cause_q, cause_d;
  logic sys_reset_q, sys_reset_d;

  // Read port
  logic [7:0] rdata_q, rdata_d;

  // Decoded bus access and source requests
  logic reg_sel;
  logic reg_wr;
  logic rtc_evt;
  logic loss_armed;
  logic loss_missing;
  logic [7:0] req;
  logic [7:0] pick;

  // Clock-loss watch, idle in low power and while reset is held
  assign loss_armed = enable_q[rsc_pkg::RSC_BIT_LOSS] && !low_power &&
                     (state_q == rsc_pkg::RSC_RUN);

  rsc_clock_loss_detector #(
    .TIMEOUT_CYCLES(LOSS_TIMEOUT_CYCLES)
  ) u_clock_loss_detector (
    .sys_clk(sys_clk),
    .rst(rst),
    .mon_clk_raw(sysclk_mon),
    .enable(loss_armed),
    .missing(loss_missing)
  );

  // Two flops on each asynchronous input before any logic
  always_comb begin
    pin_s1_d = ext_rst_n_raw;
    pin_s2_d = pin_s1_q;
    cmp_s1_d = cmp0_out_raw;
    cmp_s2_d = cmp_s1_q;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      cmp_s1_q <= 1'b1;
      cmp_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      cmp_s1_q <= cmp_s1_d;
      cmp_s2_q <= cmp_s2_d;
    end
  end

  // Register decode on page and address
  assign reg_sel = (sfr_page == rsc_pkg::RSC_REG_PAGE) &&
                   (sfr_addr == rsc_pkg::RSC_REG_ADDR);
  assign reg_wr = reg_sel && sfr_wr && (state_q == rsc_pkg::RSC_RUN);

  // Real-time clock events, qualified by their own enables
  assign rtc_evt = (rtc_clk_detect_en && rtc_clk_slow) ||
                   (rtc_alarm_en && rtc_alarm_match);

  // Per-source requests laid out like the register bits
  always_comb begin
    req = rsc_pkg::RSC_BYTE_ZERO;
    // No low-power gate here: the clock keeps its reset in sleep
    req[rsc_pkg::RSC_BIT_RTC] = rtc_evt &&
      enable_q[rsc_pkg::RSC_BIT_RTC];
    req[rsc_pkg::RSC_BIT_FLASH] = flash_error;
    // In low power the comparator counts only as a wake source
    req[rsc_pkg::RSC_BIT_CMP] = !cmp_s2_q &&
      enable_q[rsc_pkg::RSC_BIT_CMP] &&
      (!low_power || cmp0_wake_en);
    req[rsc_pkg::RSC_BIT_SW] = reg_wr &&
      sfr_wdata[rsc_pkg::RSC_BIT_SW];
    req[rsc_pkg::RSC_BIT_WDT] = wdt_overflow && !low_power;
    req[rsc_pkg::RSC_BIT_LOSS] = loss_missing;
    req[rsc_pkg::RSC_BIT_POR] = vdd_below_rst &&
      enable_q[rsc_pkg::RSC_BIT_POR];
    req[rsc_pkg::RSC_BIT_PIN] = !pin_s2_q;
  end

  // Fixed priority keeps exactly one cause flag when several fire
  always_comb begin
    pick = rsc_pkg::RSC_BYTE_ZERO;
    if (req[rsc_pkg::RSC_BIT_PIN]) begin
      pick[rsc_pkg::RSC_BIT_PIN] = 1'b1;
    end else if (req[rsc_pkg::RSC_BIT_POR]) begin
      pick[rsc_pkg::RSC_BIT_POR] = 1'b1;
    end else if (req[rsc_pkg::RSC_BIT_LOSS]) begin
      pick[rsc_pkg::RSC_BIT_LOSS] = 1'b1;
    end else if (req[rsc_pkg::RSC_BIT_WDT]) begin
      pick[rsc_pkg::RSC_BIT_WDT] = 1'b1;
    end else if (req[rsc_pkg::RSC_BIT_FLASH]) begin
      pick[rsc_pkg::RSC_BIT_FLASH] = 1'b1;
    end else if (req[rsc_pkg::RSC_BIT_CMP]) begin
      pick[rsc_pkg::RSC_BIT_CMP] = 1'b1;
    end else if (req[rsc_pkg::RSC_BIT_RTC]) begin
      pick[rsc_pkg::RSC_BIT_RTC] = 1'b1;
    end else if (req[rsc_pkg::RSC_BIT_SW]) begin
      pick[rsc_pkg::RSC_BIT_SW] = 1'b1;
    end
  end

  // Sequencer: enter hold on any request, leave once the hold count runs out and pin and supply are released.
  // Only sys_reset is driven; the pin is an input and never driven back.
  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    enable_d = enable_q;
    cause_d = cause_q;
    unique case (state_q)
      rsc_pkg::RSC_RUN: begin
        if (req != rsc_pkg::RSC_BYTE_ZERO) begin
          state_d = rsc_pkg::RSC_HOLD;
          hold_d = HOLD_LOAD;
          // Only the chosen source's flag survives
          cause_d = pick;
          // Supply reset leaves only the power flag meaningful
          if (pick[rsc_pkg::RSC_BIT_POR]) begin
            cause_d = rsc_pkg::RSC_CAUSE_POR;
          end
          enable_d = rsc_pkg::RSC_ENABLE_RESET;
        end else if (reg_wr) begin
          // Flags are not writable, only enable bits take data
          enable_d = (sfr_wdata & rsc_pkg::RSC_ENABLE_MASK) |
                     (enable_q & ~rsc_pkg::RSC_ENABLE_MASK);
        end
      end
      rsc_pkg::RSC_HOLD: begin
        if (hold_q != '0) begin
          hold_d = hold_q - HOLD_ONE;
        end
        // A still-low pin or supply keeps the chip in reset
        if (req[rsc_pkg::RSC_BIT_PIN] || vdd_below_rst) begin
          hold_d = HOLD_LOAD;
        end else if (hold_q == '0) begin
          state_d = rsc_pkg::RSC_RUN;
        end
      end
      default: begin
        state_d = rsc_pkg::RSC_HOLD;
        hold_d = HOLD_LOAD;
      end
    endcase
    sys_reset_d = (state_d == rsc_pkg::RSC_HOLD);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= rsc_pkg::RSC_RUN;
      hold_q <= '0;
      enable_q <= rsc_pkg::RSC_ENABLE_RESET;
      cause_q <= rsc_pkg::RSC_CAUSE_POR;
      sys_reset_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      enable_q <= enable_d;
      cause_q <= cause_d;
      sys_reset_q <= sys_reset_d;
    end
  end

  // Read port: plain reads show the cause, the read half of a
  // read-modify-write shows the enables so writing back keeps them
  always_comb begin
    rdata_d = rdata_q;
    if (reg_sel && sfr_rd) begin
      if (sfr_rmw) begin
        rdata_d = enable_q & rsc_pkg::RSC_ENABLE_MASK;
      end else begin
        rdata_d = cause_q;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= rsc_pkg::RSC_BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sys_reset = sys_reset_q;

endmodule : rsc_reset_source_control
`default_nettype wire

// file: shared/rsc_pkg.sv
// Constants shared by the reset cause and enable logic
`default_nettype none
package rsc_pkg;

  // Register location on the internal special function register bus
  localparam logic [7:0] RSC_REG_ADDR = 8'hef;
  localparam logic [3:0] RSC_REG_PAGE = 4'h0;

  // Bit positions inside reset_cause_and_enable
  localparam int unsigned RSC_BIT_RTC = 7;
  localparam int unsigned RSC_BIT_FLASH = 6;
  localparam int unsigned RSC_BIT_CMP = 5;
  localparam int unsigned RSC_BIT_SW = 4;
  localparam int unsigned RSC_BIT_WDT = 3;
  localparam int unsigned RSC_BIT_LOSS = 2;
  localparam int unsigned RSC_BIT_POR = 1;
  localparam int unsigned RSC_BIT_PIN = 0;

  // Bits that hold a source enable; the rest are flags only
  localparam logic [7:0] RSC_ENABLE_MASK = 8'ha6;
  // Enables after power-on: only the supply monitor armed
  localparam logic [7:0] RSC_ENABLE_RESET = 8'h02;
  // Cause word after power-on
  localparam logic [7:0] RSC_CAUSE_POR = 8'h02;
  localparam logic [7:0] RSC_BYTE_ZERO = 8'h00;

  // Clock-loss timeout: figure in microseconds, clock in MHz
  localparam int unsigned RSC_LOSS_TIMEOUT_US = 100;
  localparam int unsigned RSC_SYS_CLK_MHZ = 100;
  localparam int unsigned RSC_LOSS_TIMEOUT_CYCLES =
    RSC_LOSS_TIMEOUT_US * RSC_SYS_CLK_MHZ;

  // Cycles the system reset is held after entry; a low pin or supply restarts the count
  localparam int unsigned RSC_RESET_HOLD_CYCLES = 16;
  localparam int unsigned RSC_HOLD_W = 5;

  // Sequencer states
  typedef enum logic [1:0] {
    RSC_RUN  = 2'b01,
    RSC_HOLD = 2'b10
  } rsc_state_e;

endpackage : rsc_pkg
`default_nettype wire
